//--- legacy_card_register_access.sv
// Legacy card register set for two sockets, its index/data and memory alias
// access paths, and the I/O and memory windows that map host cycles to cards.
// Assumes host cycles arrive as one-cycle requests synchronous to clk_sys and
// that configuration space supplies the legacy I/O base and per-function bases.
`timescale 1ns/10ps

module legacy_card_register_access (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic pci_side_reset,
  input wire legacy_card_pkg::host_req_s host_req,
  input wire logic [15:0] legacy_io_base,
  input wire logic [1:0][19:0] socket_mem_base,
  input wire logic [1:0] wake_enable,
  input wire logic [1:0][7:0] card_status,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic [7:0] index_select,
  output legacy_card_pkg::card_req_s card_req,
  output legacy_card_pkg::sock_ctrl_s sock_ctrl
);

  logic [7:0] regs [0:legacy_card_pkg::NUM_REGS-1];
  logic [7:0] next_regs [0:legacy_card_pkg::NUM_REGS-1];
  logic [7:0] legacy_index_select;
  logic [7:0] next_legacy_index_select;
  logic next_rd_valid;
  logic [7:0] next_rd_data;
  legacy_card_pkg::card_req_s next_card_req;
  legacy_card_pkg::sock_ctrl_s next_sock_ctrl;

  // Bits of one register that ride through the PCI-side reset.
  function automatic logic [7:0] retain_mask(input logic [6:0] idx, input logic wake);
    logic [5:0] local_idx;
    logic [7:0] mask;
    local_idx = idx[5:0];
    mask = 8'h00;
    if (local_idx == legacy_card_pkg::IDX_GLOBAL[5:0]) begin
      mask = legacy_card_pkg::GLOBAL_CTX_MASK;
    end
    if (wake && local_idx >= legacy_card_pkg::IDX_PWR[5:0]
        && local_idx <= legacy_card_pkg::IDX_CSCCFG[5:0]) begin
      mask = legacy_card_pkg::WAKE_CTX_MASK;
    end
    return mask;
  endfunction : retain_mask

  // Identification and interface status are driven by the block, not stored.
  function automatic logic reg_writable(input logic [6:0] idx);
    return idx[5:0] != legacy_card_pkg::IDX_ID[5:0]
        && idx[5:0] != legacy_card_pkg::IDX_IFSTAT[5:0];
  endfunction : reg_writable

  // Read view of one register, including the live card status.
  function automatic logic [7:0] reg_view(input logic [6:0] idx, input logic [7:0] stored,
                                          input logic [1:0][7:0] status);
    logic [7:0] value;
    value = stored;
    if (idx[5:0] == legacy_card_pkg::IDX_ID[5:0]) begin
      value = legacy_card_pkg::ID_VALUE;
    end else if (idx[5:0] == legacy_card_pkg::IDX_IFSTAT[5:0]) begin
      value = status[idx[6]];
    end
    return value;
  endfunction : reg_view

  // Register selection and access.
  always_comb begin
    logic io_index_hit;
    logic io_data_hit;
    logic alias_hit;
    logic ctrl_hit;
    logic alias_fn;
    logic [11:0] win_off;
    logic [6:0] sel_idx;
    logic sel_ok;
    logic access;
    io_index_hit = 1'b0;
    io_data_hit = 1'b0;
    alias_hit = 1'b0;
    ctrl_hit = 1'b0;
    alias_fn = 1'b0;
    win_off = host_req.addr[11:0];
    sel_idx = 7'h00;
    sel_ok = 1'b0;
    access = 1'b0;
    for (int i = 0; i < legacy_card_pkg::NUM_REGS; i++) begin
      next_regs[i] = regs[i];
    end
    next_legacy_index_select = legacy_index_select;
    next_rd_valid = 1'b0;
    next_rd_data = 8'h00;
    next_sock_ctrl = '0;

    if (host_req.valid && host_req.is_io && host_req.addr[31:16] == 16'h0000) begin
      // Both sockets share one index/data pair at the single legacy base.
      io_index_hit = host_req.addr[15:0] == legacy_io_base;
      io_data_hit = host_req.addr[15:0] == legacy_io_base + legacy_card_pkg::IO_DATA_OFFSET;
    end
    if (host_req.valid && !host_req.is_io) begin
      for (int f = 0; f < 2; f++) begin
        if (host_req.addr[31:12] == socket_mem_base[f]) begin
          alias_fn = f[0];
          if (win_off >= legacy_card_pkg::ALIAS_FIRST
              && win_off <= legacy_card_pkg::ALIAS_LAST) begin
            alias_hit = 1'b1;
          end else if (win_off < legacy_card_pkg::ALIAS_FIRST) begin
            ctrl_hit = 1'b1;
          end
        end
      end
    end

    if (io_index_hit) begin
      if (host_req.write) begin
        next_legacy_index_select = host_req.wdata;
      end else begin
        next_rd_valid = 1'b1;
        next_rd_data = legacy_index_select;
      end
    end

    if (io_data_hit) begin
      access = 1'b1;
      // Index bit 6 picks the socket; selectors above 7Fh reach nothing.
      sel_idx = legacy_index_select[6:0];
      sel_ok = legacy_index_select[7] == 1'b0;
    end else if (alias_hit) begin
      access = 1'b1;
      // Alias offsets past the socket's 64 registers read as zero.
      sel_idx = {alias_fn, win_off[5:0]};
      sel_ok = win_off[6] == 1'b0;
    end

    if (access) begin
      if (host_req.write) begin
        // Interrupt routing at 803h/805h is ordinary read/write storage here.
        if (sel_ok && reg_writable(sel_idx)) begin
          next_regs[sel_idx] = host_req.wdata;
        end
      end else begin
        next_rd_valid = 1'b1;
        next_rd_data = sel_ok ? reg_view(sel_idx, regs[sel_idx], card_status) : 8'h00;
      end
    end

    if (ctrl_hit) begin
      next_sock_ctrl.valid = 1'b1;
      next_sock_ctrl.socket = alias_fn;
      next_sock_ctrl.write = host_req.write;
      next_sock_ctrl.offset = win_off[10:0];
      next_sock_ctrl.wdata = host_req.wdata;
    end

    if (pci_side_reset) begin
      for (int i = 0; i < legacy_card_pkg::NUM_REGS; i++) begin
        next_regs[i] = regs[i] & retain_mask(7'(i), wake_enable[i / 64]);
      end
      next_legacy_index_select = 8'h00;
      next_rd_valid = 1'b0;
      next_rd_data = 8'h00;
      next_sock_ctrl = '0;
    end
    if (rst) begin
      for (int i = 0; i < legacy_card_pkg::NUM_REGS; i++) begin
        next_regs[i] = 8'h00;
      end
      next_legacy_index_select = 8'h00;
      next_rd_valid = 1'b0;
      next_rd_data = 8'h00;
      next_sock_ctrl = '0;
    end
  end

  // Window decode: host cycles outside the register space that hit an enabled window go to a card.
  // Socket A and lower window numbers win when windows overlap.
  always_comb begin
    logic found;
    logic [6:0] base;
    logic [7:0] win_en;
    logic [15:0] io_start;
    logic [15:0] io_end;
    logic [15:0] io_ofs;
    logic [11:0] mem_start;
    logic [11:0] mem_end;
    logic [13:0] mem_ofs;
    logic [13:0] mem_page;
    logic reg_space;
    found = 1'b0;
    base = 7'h00;
    win_en = 8'h00;
    io_start = 16'h0000;
    io_end = 16'h0000;
    io_ofs = 16'h0000;
    mem_start = 12'h000;
    mem_end = 12'h000;
    mem_ofs = 14'h0000;
    mem_page = 14'h0000;
    next_card_req = '0;
    reg_space = 1'b0;

    if (host_req.is_io) begin
      reg_space = host_req.addr[15:0] == legacy_io_base
          || host_req.addr[15:0] == legacy_io_base + legacy_card_pkg::IO_DATA_OFFSET;
    end else begin
      reg_space = host_req.addr[31:12] == socket_mem_base[0]
          || host_req.addr[31:12] == socket_mem_base[1];
    end

    if (host_req.valid && !reg_space && !rst && !pci_side_reset) begin
      for (int s = 0; s < 2; s++) begin
        base = s[0] ? legacy_card_pkg::SOCKET_B_BASE : 7'h00;
        win_en = regs[base + legacy_card_pkg::IDX_WINEN];
        if (host_req.is_io && host_req.addr[31:16] == 16'h0000) begin
          for (int w = 0; w < legacy_card_pkg::NUM_IO_WIN; w++) begin
            io_start = {regs[base + legacy_card_pkg::IDX_IOWIN_BASE
                             + 7'(w) * legacy_card_pkg::IO_WIN_STRIDE + 7'd1],
                        regs[base + legacy_card_pkg::IDX_IOWIN_BASE
                             + 7'(w) * legacy_card_pkg::IO_WIN_STRIDE]};
            io_end = {regs[base + legacy_card_pkg::IDX_IOWIN_BASE
                           + 7'(w) * legacy_card_pkg::IO_WIN_STRIDE + 7'd3],
                      regs[base + legacy_card_pkg::IDX_IOWIN_BASE
                           + 7'(w) * legacy_card_pkg::IO_WIN_STRIDE + 7'd2]};
            io_ofs = {regs[base + legacy_card_pkg::IDX_IOOFS_BASE
                           + 7'(w) * legacy_card_pkg::IO_OFS_STRIDE + 7'd1],
                      regs[base + legacy_card_pkg::IDX_IOOFS_BASE
                           + 7'(w) * legacy_card_pkg::IO_OFS_STRIDE]};
            // Byte granularity: every address bit takes part in the compare.
            if (!found && win_en[legacy_card_pkg::WINEN_IO_LSB + w]
                && host_req.addr[15:0] >= io_start && host_req.addr[15:0] <= io_end) begin
              found = 1'b1;
              next_card_req.valid = 1'b1;
              next_card_req.is_io = 1'b1;
              next_card_req.write = host_req.write;
              next_card_req.socket = s[0];
              next_card_req.addr = {10'h000, 16'(host_req.addr[15:0] + io_ofs)};
              next_card_req.wdata = host_req.wdata;
            end
          end
        end else if (!host_req.is_io && host_req.addr[31:24] == 8'h00) begin
          for (int w = 0; w < legacy_card_pkg::NUM_MEM_WIN; w++) begin
            mem_start = {regs[base + legacy_card_pkg::IDX_MEMWIN_BASE
                              + 7'(w) * legacy_card_pkg::MEM_WIN_STRIDE + 7'd1][3:0],
                         regs[base + legacy_card_pkg::IDX_MEMWIN_BASE
                              + 7'(w) * legacy_card_pkg::MEM_WIN_STRIDE]};
            mem_end = {regs[base + legacy_card_pkg::IDX_MEMWIN_BASE
                            + 7'(w) * legacy_card_pkg::MEM_WIN_STRIDE + 7'd3][3:0],
                       regs[base + legacy_card_pkg::IDX_MEMWIN_BASE
                            + 7'(w) * legacy_card_pkg::MEM_WIN_STRIDE + 7'd2]};
            mem_ofs = {regs[base + legacy_card_pkg::IDX_MEMWIN_BASE
                            + 7'(w) * legacy_card_pkg::MEM_WIN_STRIDE + 7'd5][5:0],
                       regs[base + legacy_card_pkg::IDX_MEMWIN_BASE
                            + 7'(w) * legacy_card_pkg::MEM_WIN_STRIDE + 7'd4]};
            // 4K granularity: only page bits are compared and relocated.
            if (!found && win_en[legacy_card_pkg::WINEN_MEM_LSB + w]
                && host_req.addr[23:12] >= mem_start && host_req.addr[23:12] <= mem_end) begin
              found = 1'b1;
              mem_page = 14'({2'b00, host_req.addr[23:12]} + mem_ofs);
              next_card_req.valid = 1'b1;
              next_card_req.is_io = 1'b0;
              next_card_req.write = host_req.write;
              next_card_req.socket = s[0];
              next_card_req.addr = {mem_page, host_req.addr[11:0]};
              next_card_req.wdata = host_req.wdata;
            end
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < legacy_card_pkg::NUM_REGS; i++) begin
      regs[i] <= next_regs[i];
    end
    legacy_index_select <= next_legacy_index_select;
    index_select <= next_legacy_index_select;
    rd_valid <= next_rd_valid;
    rd_data <= next_rd_data;
    card_req <= next_card_req;
    sock_ctrl <= next_sock_ctrl;
  end

endmodule : legacy_card_register_access

//--- legacy_card_pkg.sv
// Constants and carrier types for the legacy card register access block.
// Assumes a single 125 MHz clock domain and byte-wide host register cycles.
package legacy_card_pkg;

  // Legacy register indexes, local to one socket (socket B adds SOCKET_B_BASE).
  localparam logic [6:0] IDX_ID = 7'h00;
  localparam logic [6:0] IDX_IFSTAT = 7'h01;
  localparam logic [6:0] IDX_PWR = 7'h02;
  localparam logic [6:0] IDX_CSCCFG = 7'h05;
  localparam logic [6:0] IDX_WINEN = 7'h06;
  localparam logic [6:0] IDX_IOWIN_BASE = 7'h08;
  localparam logic [6:0] IO_WIN_STRIDE = 7'h04;
  localparam logic [6:0] IDX_IOOFS_BASE = 7'h36;
  localparam logic [6:0] IO_OFS_STRIDE = 7'h02;
  localparam logic [6:0] IDX_MEMWIN_BASE = 7'h10;
  localparam logic [6:0] MEM_WIN_STRIDE = 7'h08;
  localparam logic [6:0] IDX_GLOBAL = 7'h1E;
  localparam logic [6:0] SOCKET_B_BASE = 7'h40;
  localparam logic [6:0] SOCKET_LAST = 7'h3F;
  localparam int NUM_REGS = 128;

  // Window enable register layout.
  localparam int WINEN_MEM_LSB = 0;
  localparam int WINEN_IO_LSB = 6;
  localparam int NUM_IO_WIN = 2;
  localparam int NUM_MEM_WIN = 5;

  // Host address map.
  localparam logic [15:0] IO_DATA_OFFSET = 16'h0001;
  localparam logic [11:0] ALIAS_FIRST = 12'h800;
  localparam logic [11:0] ALIAS_LAST = 12'h844;
  localparam logic [7:0] CFG_SOCKET_BAR = 8'h10;

  // Identification value is arbitrary.
  localparam logic [7:0] ID_VALUE = 8'h5A;

  // Bits kept through the PCI-side reset.
  localparam logic [7:0] GLOBAL_CTX_MASK = 8'h0F;
  localparam logic [7:0] WAKE_CTX_MASK = 8'hFF;

  typedef struct packed {
    logic valid;
    logic is_io;
    logic write;
    logic [31:0] addr;
    logic [7:0] wdata;
  } host_req_s;

  typedef struct packed {
    logic valid;
    logic is_io;
    logic write;
    logic socket;
    logic [25:0] addr;
    logic [7:0] wdata;
  } card_req_s;

  typedef struct packed {
    logic valid;
    logic socket;
    logic write;
    logic [10:0] offset;
    logic [7:0] wdata;
  } sock_ctrl_s;

endpackage : legacy_card_pkg

//--- host_model.sv
// Host model that issues one-cycle I/O and memory requests to the register block.
// Assumes the bench calls xfer from its main sequence and that nothing answers with a stall.
`timescale 1ns/10ps

module host_model (
  input wire logic clk_sys,
  output legacy_card_pkg::host_req_s host_req
);
  initial host_req = '0;

  task xfer(input logic is_io, input logic write, input logic [31:0] addr,
            input logic [7:0] wdata);
    @(negedge clk_sys);
    host_req = '{valid: 1'b1, is_io: is_io, write: write, addr: addr, wdata: wdata};
    @(negedge clk_sys);
    // An idle bus carries inverted garbage, so a decode of stale fields cannot pass by luck.
    host_req.valid = 1'b0;
    host_req.addr = ~host_req.addr;
    host_req.wdata = ~host_req.wdata;
  endtask : xfer
endmodule : host_model

//--- legacy_card_sva.sv
// Checker for the legacy card register block, attached by bind to its ports.
// Assumes one clock domain; rst quiets every property, pci_side_reset every one but AST_PCI_RESET.
`timescale 1ns/10ps

module legacy_card_sva (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic pci_side_reset,
  input wire legacy_card_pkg::host_req_s host_req,
  input wire logic [15:0] legacy_io_base,
  input wire logic [1:0][19:0] socket_mem_base,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  input wire logic [7:0] index_select,
  input wire legacy_card_pkg::card_req_s card_req,
  input wire legacy_card_pkg::sock_ctrl_s sock_ctrl
);
  logic io_ok;
  logic idx_hit;
  logic dat_hit;
  logic mem_hit;
  logic [11:0] ofs;
  assign io_ok = host_req.valid && host_req.is_io && host_req.addr[31:16] == 16'h0000;
  assign idx_hit = io_ok && host_req.addr[15:0] == legacy_io_base;
  assign dat_hit = io_ok && host_req.addr[15:0] == legacy_io_base + 16'h0001;
  assign mem_hit = host_req.valid && !host_req.is_io && (host_req.addr[31:12] ==
    socket_mem_base[0] || host_req.addr[31:12] == socket_mem_base[1]);
  assign ofs = host_req.addr[11:0];

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst || pci_side_reset);

  AST_IDX_LATCH: assert property (
    idx_hit && host_req.write |=> index_select == $past(host_req.wdata))
    else $error("index selector did not take the written value");
  AST_IDX_READ: assert property (
    idx_hit && !host_req.write |=> rd_valid && rd_data == $past(index_select))
    else $error("index read did not return the selector");
  AST_DATA_READ: assert property (dat_hit && !host_req.write |=> rd_valid)
    else $error("data port read gave no answer");
  AST_ALIAS_READ: assert property (
    mem_hit && !host_req.write && ofs >= 12'h800 && ofs <= 12'h844 |=> rd_valid)
    else $error("alias read gave no answer");
  AST_ALIAS_ZERO: assert property (
    mem_hit && !host_req.write && ofs >= 12'h840 && ofs <= 12'h844 |=> rd_data == 8'h00)
    else $error("alias beyond the register set did not read zero");
  AST_CTRL: assert property (
    mem_hit && ofs < 12'h800 |=> sock_ctrl.valid && sock_ctrl.offset == $past(host_req.addr[10:0]))
    else $error("socket control access not forwarded");
  AST_BEYOND: assert property (
    mem_hit && ofs > 12'h844 |=> !rd_valid && !sock_ctrl.valid && !card_req.valid)
    else $error("access above the alias range was answered");
  AST_ANSWER_CAUSE: assert property (
    rd_valid |-> $past(host_req.valid) && !$past(host_req.write))
    else $error("read answer without a read request");
  AST_PCI_RESET: assert property (@(posedge clk_sys) disable iff (rst)
    pci_side_reset |=> index_select == 8'h00 && !rd_valid && !card_req.valid)
    else $error("outputs not cleared by the PCI-side reset");
endmodule : legacy_card_sva

bind legacy_card_register_access legacy_card_sva u_sva (.clk_sys(clk_sys), .rst(rst),
  .pci_side_reset(pci_side_reset), .host_req(host_req), .legacy_io_base(legacy_io_base),
  .socket_mem_base(socket_mem_base), .rd_valid(rd_valid), .rd_data(rd_data),
  .index_select(index_select), .card_req(card_req), .sock_ctrl(sock_ctrl));

//--- tb_top.sv
// Self-checking bench for the legacy card register block with a host model.
// Assumes the design answers reads, window hits and control hits one cycle after the request.
`timescale 1ns/10ps

module tb_top;
  localparam logic [15:0] IO_BASE = 16'h03E0;
  logic clk_sys;
  logic rst;
  logic pci_side_reset;
  logic rd_valid;
  logic [1:0] wake_enable;
  logic [1:0][7:0] card_status;
  logic [1:0][19:0] mb;
  logic [7:0] rd_data;
  logic [7:0] d;
  legacy_card_pkg::host_req_s host_req;
  legacy_card_pkg::card_req_s card_req;
  legacy_card_pkg::sock_ctrl_s sock_ctrl;
  int num_errors = 0;
  int check_count = 0;
  logic [7:0] rq[$];
  legacy_card_pkg::card_req_s cq[$];
  legacy_card_pkg::sock_ctrl_s sq[$];
  logic [20:0] cfg[14] = '{
    {1'b0, 12'h808, 8'h00}, {1'b0, 12'h809, 8'h03}, {1'b0, 12'h80A, 8'h0F},
    {1'b0, 12'h80B, 8'h03}, {1'b0, 12'h836, 8'h00}, {1'b0, 12'h837, 8'h10},
    {1'b0, 12'h806, 8'h40}, {1'b1, 12'h820, 8'h20}, {1'b1, 12'h821, 8'h00},
    {1'b1, 12'h822, 8'h21}, {1'b1, 12'h823, 8'h00}, {1'b1, 12'h824, 8'h05},
    {1'b1, 12'h825, 8'h00}, {1'b1, 12'h806, 8'h04}};

  host_model host (.clk_sys(clk_sys), .host_req(host_req));
  legacy_card_register_access DUT (.clk_sys(clk_sys), .rst(rst), .pci_side_reset(pci_side_reset),
    .host_req(host_req), .legacy_io_base(IO_BASE), .socket_mem_base(mb),
    .wake_enable(wake_enable), .card_status(card_status), .rd_valid(rd_valid),
    .rd_data(rd_data), .index_select(), .card_req(card_req), .sock_ctrl(sock_ctrl));

  // An answer with no note pending counts as a mismatch, whatever its value.
  task cmp_rd(input logic [7:0] got);
    check_count++;
    if (rq.size() == 0 || got !== rq[0]) begin
      num_errors++;
      $display("BAD rd_data expected %h seen %h", rq.size() ? rq[0] : 8'hxx, got);
    end
    if (rq.size() != 0) rq.delete(0);
  endtask : cmp_rd

  task cmp_card(input legacy_card_pkg::card_req_s got);
    check_count++;
    if (cq.size() == 0 || got !== cq[0]) begin
      num_errors++;
      $display("BAD card_req expected %h seen %h", cq.size() ? cq[0] : 38'h0, got);
    end
    if (cq.size() != 0) cq.delete(0);
  endtask : cmp_card

  task cmp_ctrl(input legacy_card_pkg::sock_ctrl_s got);
    check_count++;
    if (sq.size() == 0 || got !== sq[0]) begin
      num_errors++;
      $display("BAD sock_ctrl expected %h seen %h", sq.size() ? sq[0] : 22'h0, got);
    end
    if (sq.size() != 0) sq.delete(0);
  endtask : cmp_ctrl

  task end_of_test();
    if (rq.size() + cq.size() + sq.size() != 0) num_errors++;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  task wr(input logic [6:0] idx, input logic [7:0] v);
    host.xfer(1'b1, 1'b1, {16'h0000, IO_BASE}, {1'b0, idx});
    host.xfer(1'b1, 1'b1, {16'h0000, IO_BASE + 16'h0001}, v);
  endtask : wr

  task rd(input logic [6:0] idx, input logic [7:0] e);
    host.xfer(1'b1, 1'b1, {16'h0000, IO_BASE}, {1'b0, idx});
    rq.push_back(e);
    host.xfer(1'b1, 1'b0, {16'h0000, IO_BASE + 16'h0001}, 8'h00);
  endtask : rd

  always @(negedge clk_sys) begin
    if (rd_valid === 1'b1) cmp_rd(rd_data);
    if (card_req.valid === 1'b1) cmp_card(card_req);
    if (sock_ctrl.valid === 1'b1) cmp_ctrl(sock_ctrl);
  end

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  initial begin
    #50000;
    num_errors++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'hFD0C));
    rst = 1'b1;
    pci_side_reset = 1'b0;
    wake_enable = 2'b10;
    card_status = 16'($urandom);
    mb[0] = 20'hA0000;
    mb[1] = 20'hA0001;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    wr(7'h00, 8'h11);
    rd(7'h00, legacy_card_pkg::ID_VALUE);
    rd(7'h41, card_status[1]);
    rd(7'h01, card_status[0]);
    for (int i = 2; i < 6; i++) begin
      d = 8'($urandom);
      wr(7'(i), d);
      rq.push_back(d);
      host.xfer(1'b0, 1'b0, {mb[0], 12'h800 + 12'(i)}, 8'h00);
      d = 8'($urandom);
      host.xfer(1'b0, 1'b1, {mb[1], 12'h800 + 12'(i)}, d);
      rd(7'h40 + 7'(i), d);
    end
    rq.push_back(8'h45);
    host.xfer(1'b1, 1'b0, {16'h0000, IO_BASE}, 8'h00);
    rq.push_back(8'h00);
    host.xfer(1'b0, 1'b0, {mb[0], 12'h840}, 8'h00);
    host.xfer(1'b0, 1'b0, {mb[0], 12'h845}, 8'h00);
    // Notes are whole structs: valid, socket, write, offset, wdata.
    sq.push_back({1'b1, 1'b1, 1'b1, 11'h7FF, 8'h3C});
    host.xfer(1'b0, 1'b1, {mb[1], 12'h7FF}, 8'h3C);
    foreach (cfg[i]) host.xfer(1'b0, 1'b1, {mb[cfg[i][20]], cfg[i][19:8]}, cfg[i][7:0]);
    // Notes are whole structs: valid, is_io, write, socket, addr, wdata.
    cq.push_back({1'b1, 1'b1, 1'b0, 1'b0, 26'h0001300, 8'h00});
    host.xfer(1'b1, 1'b0, 32'h0000_0300, 8'h00);
    cq.push_back({1'b1, 1'b1, 1'b1, 1'b0, 26'h000130F, 8'h77});
    host.xfer(1'b1, 1'b1, 32'h0000_030F, 8'h77);
    host.xfer(1'b1, 1'b0, 32'h0000_0310, 8'h00);
    cq.push_back({1'b1, 1'b0, 1'b0, 1'b1, 26'h0026ABC, 8'h00});
    host.xfer(1'b0, 1'b0, 32'h0002_1ABC, 8'h00);
    host.xfer(1'b0, 1'b0, 32'h0002_2ABC, 8'h00);
    wr(7'h1E, 8'hFF);
    wr(7'h02, 8'hAA);
    wr(7'h42, 8'h55);
    @(negedge clk_sys);
    pci_side_reset = 1'b1;
    repeat (2) @(negedge clk_sys);
    pci_side_reset = 1'b0;
    rd(7'h1E, 8'h0F);
    rd(7'h02, 8'h00);
    rd(7'h42, 8'h55);
    rd(7'h06, 8'h00);
    @(negedge clk_sys);
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    rd(7'h42, 8'h00);
    rd(7'h1E, 8'h00);
    repeat (4) @(negedge clk_sys);
    end_of_test();
  end
endmodule : tb_top
